/* File: core/ftp_param_bank.sv */
// Parameter register bank of the drive tester with its decoded controls.
// Notes on behaviour
// - two-byte values: low byte at lower address
// - table index 0..19 offered at power-up
// - head code 1,2,4 picks head order
// - profile high nibble: speed/rate, 9-15 reserved
// - profile low nibble: protocol, 8-15 reserved
// - select mask bits drive four select lines
// - flag bit 7 selects user data pattern
// - flag bits stop modes and track scope
// - each port mask bit enables its port
// - option bits 7:6 give data rate
// - option bit 4 reads every fourth track
// - option bit 2 picks motor line
// - option bit 1 picks head unload method
// - option bit 0: one or two index periods
// - pass nibbles: system low, align high
// - step and index times in 0.1 ms
// - all-ones clock limit means expect no clocks
// - subtest mask bits 7 and 6
// - printer option bits 0 to 3
// - all-ones index track is skipped
// - settle samples every 0.5 ms
// - track-zero limits signed, within nine percent
//
// The APB register port and the placing of the registers were chosen for this implementation.
module ftp_param_bank
  import ftp_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_head_unload,
  input wire logic i_motor_on,
  input wire logic i_settle_run,
  input wire logic i_time_run,
  output logic [4:0] o_table_index,
  output logic o_test_head0,
  output logic o_test_head1,
  output logic [3:0] o_rate_code,
  output logic [3:0] o_proto_code,
  output logic o_profile_valid,
  output logic o_drive_select_line_0,
  output logic o_drive_select_line_1,
  output logic o_drive_select_line_2,
  output logic o_drive_select_line_3,
  output logic o_use_user_data,
  output logic o_stop_after_pass,
  output logic o_stop_on_error,
  output logic o_all_tracks,
  output logic [7:0] o_port_active,
  output logic [1:0] o_data_rate,
  output logic o_short_read,
  output logic o_motor_line,
  output logic o_alternate_motor_line,
  output logic o_head_load_line,
  output logic o_one_index_period,
  output logic [3:0] o_system_passes,
  output logic [3:0] o_align_passes,
  output logic [15:0] o_step_time,
  output logic o_time_tick,
  output logic o_expect_no_clock,
  output logic [15:0] o_clock_limit,
  output logic o_write_read_subtest_a,
  output logic o_write_read_subtest_b,
  output logic [3:0] o_printer_ctl,
  output logic [2:0] o_track_measure,
  output logic o_settle_sample,
  output logic [7:0] o_settle_threshold,
  output logic o_t0_limits_ok
);

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;

  // Release the reset through two flops; assertion is immediate.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  wire rst_n = rst_sync_q;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic [7:0] regs_q [0:20];
  logic [7:0] regs_d [0:20];

  wire access = i_psel && i_penable;
  wire aligned = (i_paddr[1:0] == 2'b00);
  wire [5:0] word = i_paddr[7:2];
  wire is_bank = aligned && (word <= 6'd20);
  wire is_status = (i_paddr == OFS_STATUS);
  wire mapped = is_bank || is_status;
  wire wr_en = access && i_pwrite && is_bank && i_pstrb[0];
  wire [4:0] wr_idx = word[4:0];

  // Zero wait states; unmapped or misaligned addresses give an error.
  assign o_pready = 1'b1;
  assign o_pslverr = access && !mapped;

  // Every byte register is stored whole, reserved bits included.
  always_comb begin
    for (int i = 0; i <= 20; i++) begin
      regs_d[i] = regs_q[i];
    end
    if (wr_en) begin
      regs_d[wr_idx] = i_pwdata[7:0];
    end
  end

  // Register storage with documented power-up values.
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i <= 20; i++) begin
        regs_q[i] <= RST_BYTE;
      end
      regs_q[0] <= RST_TABLE_SEL;
      regs_q[1] <= RST_HEAD_SEL;
      regs_q[16] <= RST_SKIP_TRACK;
      regs_q[17] <= RST_SKIP_TRACK;
      regs_q[18] <= RST_SKIP_TRACK;
    end else begin
      for (int i = 0; i <= 20; i++) begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Named views of the stored bytes
  // ----------------------------------------------------------------
  wire [7:0] table_sel = regs_q[OFS_TABLE_SEL[6:2]];
  wire [7:0] head_sel = regs_q[OFS_HEAD_SEL[6:2]];
  wire [7:0] profile = regs_q[OFS_PROFILE[6:2]];
  wire [7:0] ds_mask = regs_q[OFS_DS_MASK[6:2]];
  wire [7:0] flags = regs_q[OFS_TEST_FLAGS[6:2]];
  wire [7:0] port_mask = regs_q[OFS_PORT_MASK[6:2]];
  wire [7:0] options = regs_q[OFS_OPTIONS[6:2]];
  wire [7:0] subtests = regs_q[OFS_WR_SUBTEST[6:2]];
  wire [7:0] printer = regs_q[OFS_PRINTER[6:2]];
  wire [7:0] pass_cnt = regs_q[OFS_PASS_COUNT[6:2]];
  wire signed [7:0] t0_low = regs_q[OFS_T0_LOW[6:2]];
  wire signed [7:0] t0_high = regs_q[OFS_T0_HIGH[6:2]];

  // Two-byte values: the lower location holds the low byte.
  wire [15:0] step_time = {regs_q[OFS_STEP_HI[6:2]],
                           regs_q[OFS_STEP_LO[6:2]]};
  wire [15:0] clk_limit = {regs_q[OFS_CLK_LIM_HI[6:2]],
                           regs_q[OFS_CLK_LIM_LO[6:2]]};

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  // An index past the last table falls back to table zero.
  wire table_ok = (table_sel <= TABLE_LAST);
  wire [4:0] table_idx = table_ok ? table_sel[4:0] : 5'h00;

  // Head order; any other code tests no head.
  ftp_heads_t heads;
  assign heads = (head_sel == HEAD_ONLY0) ? FTP_HEADS_ZERO :
                 (head_sel == HEAD_BOTH) ? FTP_HEADS_BOTH :
                 (head_sel == HEAD_ONLY1) ? FTP_HEADS_ONE :
                 FTP_HEADS_NONE;

  // Reserved profile codes are flagged and not passed on.
  wire rate_ok = (profile[7:4] <= RATE_CODE_LAST);
  wire proto_ok = (profile[3:0] <= PROTO_CODE_LAST);

  // Head unload by select lines drops every select line.
  wire ds_gate = !(options[OPT_UNLOAD_DS] && i_head_unload);
  wire [3:0] ds_out = ds_mask[3:0] & {4{ds_gate}};

  // Motor line choice between the narrow and wide cable.
  wire motor_alt = options[OPT_ALT_MOTOR];

  // Clock limit all ones means the test expects no clocks.
  wire no_clock = (clk_limit == CLK_LIM_NONE);

  // Index-to-data tracks holding all ones are skipped.
  wire [2:0] trk_meas;
  assign trk_meas[0] = (regs_q[OFS_IDX_TRK_A[6:2]] != TRACK_SKIP);
  assign trk_meas[1] = (regs_q[OFS_IDX_TRK_B[6:2]] != TRACK_SKIP);
  assign trk_meas[2] = (regs_q[OFS_IDX_TRK_C[6:2]] != TRACK_SKIP);

  // Signed track-zero limits must lie within nine percent.
  wire t0_ok = (t0_low >= T0_LIM_MIN) && (t0_low <= T0_LIM_MAX) &&
               (t0_high >= T0_LIM_MIN) && (t0_high <= T0_LIM_MAX);

  // ----------------------------------------------------------------
  // Timing enables
  // ----------------------------------------------------------------
  // One pulse per tenth of a millisecond for step and index timing.
  ftp_tick #(
    .PERIOD(UNIT_CYC)
  ) u_unit_tick (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(rst_n),
    .i_run(i_time_run),
    .o_tick(o_time_tick)
  );

  // One pulse per half millisecond for settle sampling.
  ftp_tick #(
    .PERIOD(SAMPLE_CYC)
  ) u_settle_tick (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(rst_n),
    .i_run(i_settle_run),
    .o_tick(o_settle_sample)
  );

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire [7:0] status = {3'b000, t0_ok, no_clock, table_ok, rate_ok,
                       proto_ok};
  wire [7:0] rd_byte = is_status ? status :
                       is_bank ? regs_q[wr_idx] : 8'h00;
  logic [31:0] prdata_q;

  // Read data is registered during the setup cycle.
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      prdata_q <= {24'h00_0000, rd_byte};
    end
  end

  assign o_prdata = prdata_q;

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_table_index <= 5'h00;
      o_test_head0 <= 1'b0;
      o_test_head1 <= 1'b0;
      o_rate_code <= 4'h0;
      o_proto_code <= 4'h0;
      o_profile_valid <= 1'b0;
      o_drive_select_line_0 <= 1'b0;
      o_drive_select_line_1 <= 1'b0;
      o_drive_select_line_2 <= 1'b0;
      o_drive_select_line_3 <= 1'b0;
      o_use_user_data <= 1'b0;
      o_stop_after_pass <= 1'b0;
      o_stop_on_error <= 1'b0;
      o_all_tracks <= 1'b0;
      o_port_active <= 8'h00;
      o_data_rate <= 2'b00;
      o_short_read <= 1'b0;
      o_motor_line <= 1'b0;
      o_alternate_motor_line <= 1'b0;
      o_head_load_line <= 1'b0;
      o_one_index_period <= 1'b0;
      o_system_passes <= 4'h0;
      o_align_passes <= 4'h0;
      o_step_time <= 16'h0000;
      o_expect_no_clock <= 1'b0;
      o_clock_limit <= 16'h0000;
      o_write_read_subtest_a <= 1'b0;
      o_write_read_subtest_b <= 1'b0;
      o_printer_ctl <= 4'h0;
      o_track_measure <= 3'b000;
      o_settle_threshold <= 8'h00;
      o_t0_limits_ok <= 1'b0;
    end else begin
      o_table_index <= table_idx;
      o_test_head0 <= (heads == FTP_HEADS_ZERO) ||
                      (heads == FTP_HEADS_BOTH);
      o_test_head1 <= (heads == FTP_HEADS_ONE) ||
                      (heads == FTP_HEADS_BOTH);
      o_rate_code <= rate_ok ? profile[7:4] : 4'h0;
      o_proto_code <= proto_ok ? profile[3:0] : 4'h0;
      o_profile_valid <= rate_ok && proto_ok;
      o_drive_select_line_0 <= ds_out[0];
      o_drive_select_line_1 <= ds_out[1];
      o_drive_select_line_2 <= ds_out[2];
      o_drive_select_line_3 <= ds_out[3];
      o_use_user_data <= flags[TF_USER_DATA];
      o_stop_after_pass <= flags[TF_STOP_PASS];
      o_stop_on_error <= flags[TF_STOP_ERR];
      o_all_tracks <= flags[TF_ALL_TRK];
      o_port_active <= port_mask;
      o_data_rate <= options[7:6];
      o_short_read <= options[OPT_SHORT_READ];
      o_motor_line <= i_motor_on && !motor_alt;
      o_alternate_motor_line <= i_motor_on && motor_alt;
      o_head_load_line <= !(i_head_unload &&
                            !options[OPT_UNLOAD_DS]);
      o_one_index_period <= options[OPT_ONE_INDEX];
      o_system_passes <= pass_cnt[3:0];
      o_align_passes <= pass_cnt[7:4];
      o_step_time <= step_time;
      o_expect_no_clock <= no_clock;
      o_clock_limit <= clk_limit;
      o_write_read_subtest_a <= subtests[SUB_A_BIT];
      o_write_read_subtest_b <= subtests[SUB_B_BIT];
      o_printer_ctl <= {printer[PR_SUMMARY], printer[PR_LINE_FEEDS],
                        printer[PR_MARK_ALL],
                        printer[PR_ENABLE]};
      o_track_measure <= trk_meas;
      o_settle_threshold <= regs_q[OFS_SETTLE_THR[6:2]];
      o_t0_limits_ok <= t0_ok;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_select_follow: assert property (@(posedge i_clk_sys)
    disable iff (!rst_n) ##1 o_drive_select_line_0 ==
    $past(ds_mask[0] && !(options[OPT_UNLOAD_DS] && i_head_unload)))
    else $error("select line 0 does not follow mask");

  a_unload_drops: assert property (@(posedge i_clk_sys)
    disable iff (!rst_n) (options[OPT_UNLOAD_DS] && i_head_unload) |=>
    !o_drive_select_line_0)
    else $error("select line stays on during unload");

  a_motor_exclusive: assert property (@(posedge i_clk_sys)
    disable iff (!rst_n) !(o_motor_line && o_alternate_motor_line))
    else $error("both motor lines active");

  a_step_order: assert property (@(posedge i_clk_sys)
    disable iff (!rst_n) (wr_en && word == OFS_STEP_HI[7:2]) |->
    ##2 o_step_time[15:8] == $past(i_pwdata[7:0], 2))
    else $error("step time high byte misplaced");

  a_no_clock_flag: assert property (@(posedge i_clk_sys)
    disable iff (!rst_n) ##1 o_expect_no_clock == &$past(clk_limit))
    else $error("no-clock flag wrong");

  a_table_range: assert property (@(posedge i_clk_sys)
    disable iff (!rst_n) o_table_index <= 5'h13)
    else $error("table index out of range");

  a_head_code: assert property (@(posedge i_clk_sys)
    disable iff (!rst_n) head_sel == 8'h04 |=> o_test_head1 && !o_test_head0)
    else $error("head one only not honoured");

  a_track_skip: assert property (@(posedge i_clk_sys)
    disable iff (!rst_n) (regs_q[16] == 8'hff) |=> !o_track_measure[0])
    else $error("skipped track measured");

  a_settle_spacing: assert property (@(posedge i_clk_sys)
    disable iff (!rst_n) o_settle_sample |=> !o_settle_sample [*8])
    else $error("settle samples too close");

  a_proto_reserved: assert property (@(posedge i_clk_sys)
    disable iff (!rst_n) profile[3] |=> !o_profile_valid && !(|o_proto_code))
    else $error("reserved protocol code passed on");

endmodule

/* File: core/ftp_pkg.sv */
// Package of register offsets, field positions and timing constants.
package ftp_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets on the APB bus
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_TABLE_SEL = 8'h00;
  localparam logic [7:0] OFS_HEAD_SEL = 8'h04;
  localparam logic [7:0] OFS_PROFILE = 8'h08;
  localparam logic [7:0] OFS_DS_MASK = 8'h0c;
  localparam logic [7:0] OFS_TEST_FLAGS = 8'h10;
  localparam logic [7:0] OFS_SUPPLY_MASK = 8'h14;
  localparam logic [7:0] OFS_PORT_MASK = 8'h18;
  localparam logic [7:0] OFS_OPTIONS = 8'h1c;
  localparam logic [7:0] OFS_STEP_LO = 8'h20;
  localparam logic [7:0] OFS_STEP_HI = 8'h24;
  localparam logic [7:0] OFS_WR_SUBTEST = 8'h28;
  localparam logic [7:0] OFS_PRINTER = 8'h2c;
  localparam logic [7:0] OFS_SETTLE_THR = 8'h30;
  localparam logic [7:0] OFS_PASS_COUNT = 8'h34;
  localparam logic [7:0] OFS_CLK_LIM_LO = 8'h38;
  localparam logic [7:0] OFS_CLK_LIM_HI = 8'h3c;
  localparam logic [7:0] OFS_IDX_TRK_A = 8'h40;
  localparam logic [7:0] OFS_IDX_TRK_B = 8'h44;
  localparam logic [7:0] OFS_IDX_TRK_C = 8'h48;
  localparam logic [7:0] OFS_T0_LOW = 8'h4c;
  localparam logic [7:0] OFS_T0_HIGH = 8'h50;
  localparam logic [7:0] OFS_STATUS = 8'h54;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_TABLE_SEL = 8'h00;
  localparam logic [7:0] RST_HEAD_SEL = 8'h01;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_SKIP_TRACK = 8'hff;

  // ----------------------------------------------------------------
  // Field values and positions
  // ----------------------------------------------------------------
  localparam logic [7:0] TABLE_LAST = 8'h13;
  localparam logic [7:0] HEAD_ONLY0 = 8'h01;
  localparam logic [7:0] HEAD_BOTH = 8'h02;
  localparam logic [7:0] HEAD_ONLY1 = 8'h04;
  localparam logic [3:0] RATE_CODE_LAST = 4'h8;
  localparam logic [3:0] PROTO_CODE_LAST = 4'h7;
  localparam int TF_USER_DATA = 7;
  localparam int TF_STOP_PASS = 6;
  localparam int TF_STOP_ERR = 5;
  localparam int TF_ALL_TRK = 4;
  localparam int TF_ONE_TRK = 3;
  localparam int OPT_SHORT_READ = 4;
  localparam int OPT_ALT_MOTOR = 2;
  localparam int OPT_UNLOAD_DS = 1;
  localparam int OPT_ONE_INDEX = 0;
  localparam int SUB_B_BIT = 7;
  localparam int SUB_A_BIT = 6;
  localparam int PR_ENABLE = 0;
  localparam int PR_MARK_ALL = 1;
  localparam int PR_LINE_FEEDS = 2;
  localparam int PR_SUMMARY = 3;
  localparam logic [15:0] CLK_LIM_NONE = 16'hffff;
  localparam logic [7:0] TRACK_SKIP = 8'hff;
  localparam logic signed [7:0] T0_LIM_MAX = 8'sh09;
  localparam logic signed [7:0] T0_LIM_MIN = -8'sh09;

  // ----------------------------------------------------------------
  // Timing constants
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int UNIT_US = 100;
  localparam int UNIT_CYC = CLK_HZ / 1000000 * UNIT_US;
  localparam int SAMPLE_US = 500;
  localparam int SAMPLE_CYC = CLK_HZ / 1000000 * SAMPLE_US;

  // Data rate decode of the option byte's top two bits.
  typedef enum logic [1:0] {
    FTP_RATE_500,
    FTP_RATE_1000,
    FTP_RATE_250,
    FTP_RATE_833
  } ftp_rate_t;

  // Head test order.
  typedef enum logic [1:0] {
    FTP_HEADS_NONE,
    FTP_HEADS_ZERO,
    FTP_HEADS_BOTH,
    FTP_HEADS_ONE
  } ftp_heads_t;

endpackage

/* File: core/ftp_tick.sv */
// Divider that gives a one-cycle enable every PERIOD clocks.
module ftp_tick
  import ftp_pkg::*;
#(
  parameter int PERIOD = 2000
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_run,
  output logic o_tick
);

  localparam int W = $clog2(PERIOD);
  localparam logic [W-1:0] LAST = W'(PERIOD - 1);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  wire wrap = (cnt_q == LAST);

  // The count restarts whenever the divider is held idle.
  assign cnt_d = (!i_run || wrap) ? '0 : cnt_q + W'(1);
  assign o_tick = i_run && wrap;

  // Counter register.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

/* File: sim/ftp_drive_model.sv */
// Behavioural model of the drive under test on its select and motor lines.
module ftp_drive_model (
  input wire logic i_clk,
  input wire logic [3:0] i_select,
  input wire logic i_motor,
  input wire logic i_loaded,
  output logic o_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] spin_q;
  // The spindle needs time to come up to speed after the motor starts.
  always @(posedge i_clk) begin
    if (!i_motor) begin
      spin_q <= 4'h0;
    end else if (spin_q != 4'hf) begin
      spin_q <= spin_q + 4'h1;
    end
  end
  // Ready needs a select line, a loaded head and a spindle at speed.
  assign o_ready = (|i_select) && i_loaded && (spin_q == 4'hf);
endmodule

/* File: sim/testbench.sv */
// Self-checking bench of the tester parameter bank.
module testbench
  import ftp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, psel, pen, pwr, pready, pslverr, err;
  logic unload, motor, srun, trun, h0, h1, pval, ud, sp, se, at;
  logic sr, ml, aml, hl, oip, tick, nclk, sa, sb, samp, t0ok;
  logic [7:0] paddr, ports, sthr;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0] pstrb, rate, proto, sysp, alp, prn;
  logic [4:0] tidx;
  logic [1:0] drate;
  logic [15:0] step, clim;
  logic [2:0] trk;
  wire [3:0] ds;
  wire drv_ready;
  int miscompares = 0;
  int comparisons = 0;
  ftp_param_bank dut_u (.i_clk_sys(clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_head_unload(unload), .i_motor_on(motor),
    .i_settle_run(srun), .i_time_run(trun), .o_table_index(tidx),
    .o_test_head0(h0), .o_test_head1(h1), .o_rate_code(rate),
    .o_proto_code(proto), .o_profile_valid(pval),
    .o_drive_select_line_0(ds[0]), .o_drive_select_line_1(ds[1]),
    .o_drive_select_line_2(ds[2]), .o_drive_select_line_3(ds[3]),
    .o_use_user_data(ud), .o_stop_after_pass(sp), .o_stop_on_error(se),
    .o_all_tracks(at), .o_port_active(ports), .o_data_rate(drate),
    .o_short_read(sr), .o_motor_line(ml), .o_alternate_motor_line(aml),
    .o_head_load_line(hl), .o_one_index_period(oip),
    .o_system_passes(sysp), .o_align_passes(alp), .o_step_time(step),
    .o_time_tick(tick), .o_expect_no_clock(nclk), .o_clock_limit(clim),
    .o_write_read_subtest_a(sa), .o_write_read_subtest_b(sb),
    .o_printer_ctl(prn), .o_track_measure(trk), .o_settle_sample(samp),
    .o_settle_threshold(sthr), .o_t0_limits_ok(t0ok));
  ftp_drive_model drive_u (.i_clk(clk), .i_select(ds), .i_motor(ml | aml),
    .i_loaded(hl), .o_ready(drv_ready));
  // ----------------------------------------------------------------
  // Clock, checking and bus tasks
  // ----------------------------------------------------------------
  // The 20 MHz system clock.
  initial clk = 1'b0;
  always #25 clk = ~clk;
  // Prints the counts and the verdict, then stops the run.
  task conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Compares a seen value with the expected one.
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; read data and error are taken at the ready edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      conclude();
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Writes a register and lets the decoded outputs follow.
  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
    repeat (2) @(posedge clk);
  endtask
  // Reads a register and compares the returned byte.
  task rdc(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(rdata, {24'h000000, exp});
  endtask
  // Counts the cycles between two pulses of a divider output.
  task automatic gap(input logic settle, input int want);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((settle ? samp : tick) !== 1'b1 && n < 20000);
    if (n >= 20000) begin
      miscompares++;
      conclude();
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((settle ? samp : tick) !== 1'b1 && n < 20000);
    if (n >= 20000) begin
      miscompares++;
      conclude();
    end
    chk(n, want);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset values, table index limits and head codes.
  task automatic t_table_heads();
    logic [7:0] code [4] = '{HEAD_ONLY0, HEAD_BOTH, HEAD_ONLY1, 8'h03};
    logic [1:0] heads [4] = '{2'b01, 2'b11, 2'b10, 2'b00};
    rdc(OFS_HEAD_SEL, RST_HEAD_SEL);
    chk(trk, 3'b000);
    wr(OFS_TABLE_SEL, TABLE_LAST);
    chk(tidx, 5'd19);
    wr(OFS_TABLE_SEL, 8'h14);
    chk(tidx, 5'd0);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_HEAD_SEL, code[i]);
      chk({h1, h0}, heads[i]);
    end
  endtask
  // Profile nibbles at the last codes and in the reserved range.
  task t_profile();
    wr(OFS_PROFILE, 8'h87);
    chk({pval, rate, proto}, {1'b1, 4'h8, 4'h7});
    rdc(OFS_STATUS, 8'h13);
    wr(OFS_PROFILE, 8'h98);
    chk({rate, proto}, 8'h00);
    rdc(OFS_PROFILE, 8'h98);
  endtask
  // Select mask, flags, port mask and other byte fields.
  task t_fields();
    wr(OFS_DS_MASK, 8'h05);
    chk(ds, 4'b0101);
    wr(OFS_DS_MASK, 8'h00);
    chk(ds, 4'b0000);
    wr(OFS_TEST_FLAGS, 8'he7);
    chk({ud, sp, se, at}, 4'b1110);
    rdc(OFS_TEST_FLAGS, 8'he7);
    wr(OFS_TEST_FLAGS, 8'h10);
    chk({ud, sp, se, at}, 4'b0001);
    wr(OFS_PORT_MASK, 8'haa);
    chk(ports, 8'haa);
    wr(OFS_WR_SUBTEST, 8'h80);
    chk({sb, sa}, 2'b10);
    wr(OFS_PRINTER, 8'h0d);
    chk(prn, 4'hd);
    wr(OFS_PASS_COUNT, 8'h3a);
    chk({alp, sysp}, 8'h3a);
    wr(OFS_SETTLE_THR, 8'h14);
    chk(sthr, 8'h14);
    wr(OFS_IDX_TRK_A, 8'h05);
    chk(trk, 3'b001);
  endtask
  // Option byte: all data rates, motor line, unload method, index span.
  task t_options();
    motor <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      wr(OFS_OPTIONS, {r[1:0], 6'h15});
      chk({drate, sr, aml, ml, oip}, {r[1:0], 4'hd});
    end
    wr(OFS_DS_MASK, 8'h01);
    wr(OFS_OPTIONS, 8'h00);
    chk({sr, aml, ml, oip}, 4'b0010);
    repeat (20) @(posedge clk);
    chk(drv_ready, 1'b1);
    unload <= 1'b1;
    repeat (3) @(posedge clk);
    chk({hl, ds}, 5'b00001);
    wr(OFS_OPTIONS, 8'h02);
    chk(ds, 4'b0000);
    chk(drv_ready, 1'b0);
    unload <= 1'b0;
    motor <= 1'b0;
  endtask
  // Two-byte values, clock limit, track-zero limits and unmapped access.
  task t_words();
    wr(OFS_STEP_LO, 8'h90);
    wr(OFS_STEP_HI, 8'h01);
    chk(step, 16'h0190);
    wr(OFS_CLK_LIM_LO, 8'hff);
    wr(OFS_CLK_LIM_HI, 8'hff);
    chk({nclk, clim}, {1'b1, CLK_LIM_NONE});
    wr(OFS_CLK_LIM_HI, 8'hfe);
    chk({nclk, clim}, 17'h0feff);
    wr(OFS_T0_LOW, 8'hf7);
    wr(OFS_T0_HIGH, 8'h09);
    chk(t0ok, 1'b1);
    wr(OFS_T0_HIGH, 8'h0a);
    chk(t0ok, 1'b0);
    apb(1'b0, 8'h58, 32'h00000000);
    chk(err, 1'b1);
    chk(rdata, 32'h00000000);
  endtask
  // Tenth-millisecond and half-millisecond dividers.
  task t_timers();
    trun <= 1'b1;
    gap(1'b0, UNIT_CYC);
    trun <= 1'b0;
    srun <= 1'b1;
    gap(1'b1, SAMPLE_CYC);
    srun <= 1'b0;
  endtask
  // Main sequence: reset for eight cycles, then every scenario.
  initial begin
    {rst_n, psel, pen, pwr, unload, motor, srun, trun} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    pstrb = 4'hf;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_table_heads();
    t_profile();
    t_fields();
    t_options();
    t_words();
    t_timers();
    conclude();
  end
endmodule
